// file: core/iroi_pkg.sv
// Package: constants, limit selection types and window carrier for the ROI window block
`default_nettype none
package iroi_pkg;
    localparam int unsigned IROI_DW = 16;
    localparam int unsigned IROI_SENSOR_W = 3840;
    localparam int unsigned IROI_SENSOR_H = 2748;
    // Sensor limit class selects the minimum tables
    typedef enum logic [1:0] {
        IROI_CLS_ONE = 2'h0,
        IROI_CLS_64 = 2'h1,
        IROI_CLS_LARGE = 2'h2,
        IROI_CLS_FIXED = 2'h3
    } iroi_cls_t;
    localparam logic [15:0] IROI_MIN_ONE = 16'h0001;
    localparam logic [15:0] IROI_MIN64_B1 = 16'h0040;
    localparam logic [15:0] IROI_MIN64_B2 = 16'h0020;
    localparam logic [15:0] IROI_MIN64_B3 = 16'h0016;
    localparam logic [15:0] IROI_MIN64_B4 = 16'h0010;
    localparam logic [15:0] IROI_HMIN_L_B1 = 16'h0ABC;
    localparam logic [15:0] IROI_HMIN_L_B2 = 16'h055E;
    localparam logic [15:0] IROI_HMIN_L_B4 = 16'h02AF;
    localparam logic [15:0] IROI_WMIN_L_B1 = 16'h0F00;
    localparam logic [15:0] IROI_WMIN_L_B2 = 16'h0780;
    localparam logic [15:0] IROI_WMIN_L_B4 = 16'h03C0;
    localparam logic [15:0] IROI_NO_LIMIT = 16'hFFFF;
    localparam logic [2:0] IROI_BIN_1 = 3'h1;
    localparam logic [2:0] IROI_BIN_2 = 3'h2;
    localparam logic [2:0] IROI_BIN_3 = 3'h3;
    localparam logic [2:0] IROI_BIN_4 = 3'h4;
    typedef struct packed {
        logic [15:0] col_start;
        logic [15:0] row_start;
        logic [15:0] width;
        logic [15:0] height;
    } iroi_win_t;
endpackage : iroi_pkg
`default_nettype wire

// file: core/iroi_limit.sv
// Minimum window size lookup for one axis and binning factor
`default_nettype none
module iroi_limit
    import iroi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire iroi_cls_t cls,
    input wire logic vertical,
    input wire logic [2:0] bin,
    output logic [15:0] min_size
);
    logic [15:0] min_next;
    always_comb
    begin
        min_next = IROI_NO_LIMIT;
        case (cls)
            IROI_CLS_ONE: min_next = IROI_MIN_ONE;
            IROI_CLS_FIXED: min_next = IROI_MIN_ONE;
            IROI_CLS_64:
            begin
                case (bin)
                    IROI_BIN_1: min_next = IROI_MIN64_B1;
                    IROI_BIN_2: min_next = IROI_MIN64_B2;
                    IROI_BIN_3: min_next = IROI_MIN64_B3;
                    IROI_BIN_4: min_next = IROI_MIN64_B4;
                    default: min_next = IROI_NO_LIMIT;
                endcase
            end
            IROI_CLS_LARGE:
            begin
                // Binning by 3 maps to an impossible minimum, so it is never accepted
                case (bin)
                    IROI_BIN_1: min_next = vertical ? IROI_HMIN_L_B1 : IROI_WMIN_L_B1;
                    IROI_BIN_2: min_next = vertical ? IROI_HMIN_L_B2 : IROI_WMIN_L_B2;
                    IROI_BIN_4: min_next = vertical ? IROI_HMIN_L_B4 : IROI_WMIN_L_B4;
                    default: min_next = IROI_NO_LIMIT;
                endcase
            end
            default: min_next = IROI_NO_LIMIT;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            min_size <= IROI_NO_LIMIT;
        else
            min_size <= min_next;
    end
endmodule : iroi_limit
`default_nettype wire

// file: core/iroi_window.sv
// ROI window: settings acceptance, centering and frame crop
`default_nettype none
module iroi_window
    import iroi_pkg::*;
#(
    parameter int unsigned SENSOR_W = IROI_SENSOR_W,
    parameter int unsigned SENSOR_H = IROI_SENSOR_H,
    parameter logic [15:0] COL_INC = 16'h0001,
    parameter logic [15:0] ROW_INC = 16'h0001,
    parameter logic [15:0] FIXED_WMIN = 16'h0008
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire iroi_cls_t sensor_class,
    input wire logic [2:0] bin_horizontal,
    input wire logic [2:0] bin_vertical,
    input wire logic center_horizontal,
    input wire logic center_vertical,
    input wire logic acquiring,
    input wire iroi_win_t req_win,
    input wire logic req_valid,
    input wire logic frame_start,
    input wire logic pix_valid,
    input wire logic [15:0] pix_col,
    input wire logic [15:0] pix_row,
    output iroi_win_t active_win,
    output logic [15:0] largest_window_width,
    output logic [15:0] largest_window_height,
    output logic req_rejected,
    output logic pix_in_window
);
    typedef struct packed {
        iroi_win_t pend;
        iroi_win_t act;
        logic rej;
        logic inwin;
    } iroi_state_t;
    iroi_state_t st_reg;
    iroi_state_t st_next;
    logic [15:0] wmin;
    logic [15:0] hmin;
    logic [15:0] wmin_eff;
    logic [15:0] ext_w;
    logic [15:0] ext_h;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] bin_div(input logic [15:0] ext, input logic [2:0] b);
        logic [15:0] r;
        r = ext;
        case (b)
            IROI_BIN_2: r = ext >> 1;
            IROI_BIN_3: r = 16'(ext / 16'h0003);
            IROI_BIN_4: r = ext >> 2;
            default: r = ext;
        endcase
        return r;
    endfunction : bin_div

    // Half the slack, truncated to the increment grid
    function automatic logic [15:0] center_off(input logic [15:0] ext, input logic [15:0] sz,
                                               input logic [15:0] inc);
        logic [15:0] half;
        half = (ext > sz) ? 16'((ext - sz) >> 1) : 16'h0000;
        return 16'(half - (half % inc));
    endfunction : center_off

    ////////////////////////////////////////////////////////////////////////////
    iroi_limit u_wlim (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cls(sensor_class),
        .vertical(1'b0),
        .bin(bin_horizontal),
        .min_size(wmin)
    );
    iroi_limit u_hlim (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cls(sensor_class),
        .vertical(1'b1),
        .bin(bin_vertical),
        .min_size(hmin)
    );

    // Fixed-minimum sensors keep their width minimum at every binning factor
    assign wmin_eff = (sensor_class == IROI_CLS_FIXED) ? FIXED_WMIN : wmin;
    // Extents in virtual units when binning is on
    assign ext_w = bin_div(16'(SENSOR_W), bin_horizontal);
    assign ext_h = bin_div(16'(SENSOR_H), bin_vertical);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next = st_reg;
        st_next.rej = 1'b0;
        if (req_valid)
        begin
            // Size is frozen while capturing; host is expected to stop first
            if (acquiring)
            begin
                st_next.pend.col_start = req_win.col_start;
                st_next.pend.row_start = req_win.row_start;
                st_next.rej = (req_win.width != st_reg.pend.width) ||
                              (req_win.height != st_reg.pend.height);
            end
            else if (req_win.width < wmin_eff || req_win.height < hmin ||
                     req_win.width > ext_w || req_win.height > ext_h)
            begin
                st_next.rej = 1'b1;
            end
            else
            begin
                st_next.pend = req_win;
            end
        end
        if (center_horizontal)
            st_next.pend.col_start = center_off(ext_w, st_next.pend.width, COL_INC);
        if (center_vertical)
            st_next.pend.row_start = center_off(ext_h, st_next.pend.height, ROW_INC);
        // While acquiring, offsets take effect only at frame boundaries so a frame is never torn; when idle they take effect at once
        if (frame_start || !acquiring)
            st_next.act = st_next.pend;
        st_next.inwin = pix_valid &&
            pix_col >= st_reg.act.col_start &&
            pix_col - st_reg.act.col_start < st_reg.act.width &&
            pix_row >= st_reg.act.row_start &&
            pix_row - st_reg.act.row_start < st_reg.act.height;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg.pend.col_start <= 16'h0000;
            st_reg.pend.row_start <= 16'h0000;
            st_reg.pend.width <= 16'(IROI_SENSOR_W);
            st_reg.pend.height <= 16'(IROI_SENSOR_H);
            st_reg.act.col_start <= 16'h0000;
            st_reg.act.row_start <= 16'h0000;
            st_reg.act.width <= 16'(IROI_SENSOR_W);
            st_reg.act.height <= 16'(IROI_SENSOR_H);
            st_reg.rej <= 1'b0;
            st_reg.inwin <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign active_win = st_reg.act;
    assign req_rejected = st_reg.rej;
    assign pix_in_window = st_reg.inwin;
    assign largest_window_width = ext_w;
    assign largest_window_height = ext_h;
endmodule : iroi_window
`default_nettype wire

// file: verif/iroi_window_props.sv
// Checker: port properties of the ROI window block
`default_nettype none
module iroi_window_props
    import iroi_pkg::*;
#(
    parameter logic [15:0] COL_INC = 16'h0001,
    parameter logic [15:0] ROW_INC = 16'h0001
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire iroi_cls_t sensor_class,
    input wire logic [2:0] bin_horizontal,
    input wire logic [2:0] bin_vertical,
    input wire logic center_horizontal,
    input wire logic center_vertical,
    input wire logic acquiring,
    input wire iroi_win_t req_win,
    input wire logic req_valid,
    input wire logic pix_valid,
    input wire logic [15:0] pix_col,
    input wire logic [15:0] pix_row,
    input wire iroi_win_t active_win,
    input wire logic [15:0] largest_window_width,
    input wire logic [15:0] largest_window_height,
    input wire logic req_rejected,
    input wire logic pix_in_window
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic [15:0] gc = (largest_window_width - active_win.width) >> 1;
    wire logic [15:0] gr = (largest_window_height - active_win.height) >> 1;
    // Limits are looked up one edge late, so binning must have settled
    sequence s_idle_req;
        !acquiring && req_valid && $stable(sensor_class) && $stable(bin_horizontal) && $stable(bin_vertical);
    endsequence
    a_reject_cause: assert property (req_rejected |-> $past(req_valid))
        else $error("rejection without request");
    a_size_frozen: assert property (acquiring && $past(acquiring) |-> $stable(active_win.width)
        && $stable(active_win.height)) else $error("size changed during capture");
    a_height_min: assert property (s_idle_req ##0 (sensor_class == IROI_CLS_64 &&
        bin_vertical == IROI_BIN_2 && req_win.height < IROI_MIN64_B2) |=> req_rejected) else $error("short height taken");
    a_width_min: assert property (s_idle_req ##0 (sensor_class == IROI_CLS_LARGE &&
        bin_horizontal == IROI_BIN_2 && req_win.width < IROI_WMIN_L_B2) |=> req_rejected) else $error("narrow width taken");
    a_center_cols: assert property (center_horizontal && $past(center_horizontal) && $stable(gc)
        |-> active_win.col_start == gc - gc % COL_INC) else $error("columns not centered");
    a_center_rows: assert property (center_vertical && $past(center_vertical) && $stable(gr)
        |-> active_win.row_start == gr - gr % ROW_INC) else $error("rows not centered");
    a_extent_bin: assert property (bin_horizontal == IROI_BIN_2 |-> largest_window_width == 16'(IROI_SENSOR_W / 2))
        else $error("binned extent wrong");
    a_crop_window: assert property (pix_in_window == $past(pix_valid && pix_col >= active_win.col_start
        && pix_col - active_win.col_start < active_win.width && pix_row >= active_win.row_start
        && pix_row - active_win.row_start < active_win.height)) else $error("crop flag wrong");
endmodule : iroi_window_props
bind iroi_window iroi_window_props #(.COL_INC(COL_INC), .ROW_INC(ROW_INC)) u_props (.ref_clk, .rst_n,
    .sensor_class, .bin_horizontal, .bin_vertical, .center_horizontal, .center_vertical, .acquiring, .req_win,
    .req_valid, .pix_valid, .pix_col, .pix_row, .active_win, .largest_window_width, .largest_window_height,
    .req_rejected, .pix_in_window);
`default_nettype wire

// file: verif/tb_iroi_window.sv
// Testbench: ROI window limits, centering, on-the-fly offsets and crop
`default_nettype none
module tb_iroi_window
    import iroi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [1:0] c; logic [2:0] b; logic [15:0] w; logic [15:0] h; logic rj;} iroi_row_t;
    // Each reject row follows an accepted or reject row; the test expects the window of the last accepted row to be kept
    localparam iroi_row_t ROWS [12] = '{
        '{2'h1, 3'h2, 16'h0020, 16'h0020, 1'h0}, '{2'h1, 3'h2, 16'h0020, 16'h001F, 1'h1},
        '{2'h1, 3'h3, 16'h0016, 16'h0016, 1'h0}, '{2'h1, 3'h4, 16'h0010, 16'h0010, 1'h0},
        '{2'h1, 3'h4, 16'h000F, 16'h0010, 1'h1}, '{2'h2, 3'h2, 16'h0780, 16'h055E, 1'h0},
        '{2'h2, 3'h2, 16'h0780, 16'h055D, 1'h1}, '{2'h2, 3'h2, 16'h077F, 16'h055E, 1'h1},
        '{2'h2, 3'h4, 16'h03C0, 16'h02AF, 1'h0}, '{2'h2, 3'h3, 16'h0500, 16'h0394, 1'h1},
        '{2'h3, 3'h4, 16'h0007, 16'h0001, 1'h1}, '{2'h3, 3'h4, 16'h0008, 16'h0001, 1'h0}};
    logic ref_clk = 1'h0, rst_n = 1'h0, cx = 1'h0, cy = 1'h0, acq = 1'h0, rv = 1'h0, fs = 1'h0, pv = 1'h0, rej, inw;
    logic [2:0] bh = 3'h1, bv = 3'h1;
    logic [1:0] cls = 2'h1;
    logic [15:0] pc = 16'h0000, pr = 16'h0000, lw, lh;
    iroi_win_t rw = '0, aw, ew;
    int errors = 0, samples_checked = 0;
    iroi_window dut (.ref_clk(ref_clk), .rst_n(rst_n), .sensor_class(iroi_cls_t'(cls)), .bin_horizontal(bh),
        .bin_vertical(bv), .center_horizontal(cx), .center_vertical(cy), .acquiring(acq), .req_win(rw),
        .req_valid(rv), .frame_start(fs), .pix_valid(pv), .pix_col(pc), .pix_row(pr), .active_win(aw),
        .largest_window_width(lw), .largest_window_height(lh), .req_rejected(rej), .pix_in_window(inw));
    //////////////////////////////////////////////////
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic req(input iroi_win_t w);
        @(posedge ref_clk);
        rw <= w;
        rv <= 1'h1;
        @(posedge ref_clk);
        rv <= 1'h0;
        @(negedge ref_clk);
    endtask : req
    task automatic frame();
        @(posedge ref_clk);
        fs <= 1'h1;
        @(posedge ref_clk);
        fs <= 1'h0;
        @(negedge ref_clk);
    endtask : frame
    task automatic pix(input logic [15:0] c, input logic [15:0] r, input logic e);
        @(posedge ref_clk);
        pc <= c;
        pr <= r;
        pv <= 1'h1;
        @(posedge ref_clk);
        pv <= 1'h0;
        @(negedge ref_clk);
        chk(64'(inw), 64'(e));
    endtask : pix
    task automatic complete_run();
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial
        forever #20 ref_clk = ~ref_clk;
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        chk(aw, {32'h0, 16'(IROI_SENSOR_W), 16'(IROI_SENSOR_H)});
        rst_n <= 1'h1;
        ew = aw;
        foreach (ROWS[i])
        begin
            @(posedge ref_clk);
            cls <= ROWS[i].c;
            bh <= ROWS[i].b;
            bv <= ROWS[i].b;
            req({32'h0, ROWS[i].w, ROWS[i].h});
            if (!ROWS[i].rj)
                ew = {32'h0, ROWS[i].w, ROWS[i].h};
            chk(64'(rej), 64'(ROWS[i].rj));
            chk(aw, ew);
        end
        req({32'h0, 16'h0040, 16'h0040});
        @(posedge ref_clk);
        cx <= 1'h1;
        cy <= 1'h1;
        bh <= IROI_BIN_2;
        repeat (3) @(negedge ref_clk);
        chk(64'(lw), 64'(IROI_SENSOR_W / 2));
        chk(64'(lh), 64'(IROI_SENSOR_H / 4));
        chk(aw[63:32], {16'((IROI_SENSOR_W / 2 - 64) / 2), 16'((IROI_SENSOR_H / 4 - 64) / 2)});
        @(posedge ref_clk);
        cx <= 1'h0;
        cy <= 1'h0;
        bh <= IROI_BIN_1;
        acq <= 1'h1;
        req({16'h0010, 16'h0008, 16'h0040, 16'h0040});
        chk(64'(rej), 64'h0);
        frame();
        chk(aw, {16'h0010, 16'h0008, 16'h0040, 16'h0040});
        req({16'h0010, 16'h0008, 16'h0020, 16'h0040});
        chk(64'(rej), 64'h1);
        frame();
        chk(aw, {16'h0010, 16'h0008, 16'h0040, 16'h0040});
        @(posedge ref_clk);
        acq <= 1'h0;
        pix(16'h0010, 16'h0008, 1'h1);
        pix(16'h000F, 16'h0008, 1'h0);
        pix(16'h004F, 16'h0047, 1'h1);
        pix(16'h0050, 16'h0008, 1'h0);
        pix(16'h0010, 16'h0048, 1'h0);
        complete_run();
    end
endmodule : tb_iroi_window
`default_nettype wire
